// ==== design/pcf_top.sv ====
// carrier modulator, fault trip handler and three-channel capture unit
// assumes single clock, synchronous inputs, register reads answered in the next cycle
`timescale 1ns/1ps
`default_nettype none

module pcf_top (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [pcf_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [31:0]                  reg_rdata,
  input  wire logic                         pwm_a_in,
  input  wire logic                         pwm_b_in,
  input  wire logic                         timer_counting_down,
  input  wire logic                         timer_at_period_event,
  input  wire logic                         timer_at_zero_event,
  input  wire logic [2:0]                   fault_input,
  input  wire logic [2:0]                   capture_input,
  input  wire logic                         timer_sync_out,
  input  wire logic                         module_sync_in,
  output logic                              output_a,
  output logic                              output_b,
  output logic                              cycle_trip_active,
  output logic                              latched_trip_active,
  output logic      [2:0]                   cycle_trip_irq,
  output logic      [2:0]                   latched_trip_irq,
  output logic      [2:0]                   capture_irq
);

  pcf_pkg::pcf_state_s q;
  pcf_pkg::pcf_state_s d;

  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    unique case (pcf_pkg::pcf_act_e'(act))
      pcf_pkg::PCF_ACT_NONE:   apply_action = cur;
      pcf_pkg::PCF_ACT_LOW:    apply_action = 1'b0;
      pcf_pkg::PCF_ACT_HIGH:   apply_action = 1'b1;
      pcf_pkg::PCF_ACT_TOGGLE: apply_action = ~cur;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] off);
    hit = (reg_addr == off);
  endfunction

  logic [1:0] pwm_in;
  logic [1:0] carried;
  logic [2:0] events;
  logic [2:0] ev_rise;
  logic [2:0] ev_cycle;
  logic [2:0] ev_latched;
  logic       cyc_fire;
  logic       lat_fire;
  logic       release_pt;
  logic       clear_now;
  logic       sw_cyc;
  logic       sw_lat;
  logic [2:0] sw_force;
  logic       sync_now;
  logic [1:0] act_a_cyc;
  logic [1:0] act_b_cyc;
  logic [1:0] act_a_lat;
  logic [1:0] act_b_lat;

  always_comb
  begin
    d = q;
    pwm_in = {pwm_b_in, pwm_a_in};
    carried = 2'b00;

    // carrier: divided tick, first pulse, then duty chopping
    for (int i = 0; i < 2; i++)
    begin
      logic tick;
      logic rise;
      tick = 1'b0;
      rise = pwm_in[i] & ~q.car[i].prev_in;
      d.car[i].prev_in = pwm_in[i];
      if (!q.carrier_config[pcf_pkg::CC_EN_BIT])
      begin
        carried[i] = pwm_in[i];
        d.car[i].presc_cnt = 4'h0;
        d.car[i].phase = 3'h0;
        d.car[i].in_first = 1'b0;
      end
      else if (!pwm_in[i])
      begin
        carried[i] = 1'b0;
        d.car[i].in_first = 1'b0;
      end
      else if (rise)
      begin
        // restart divider so the first pulse has its full length
        carried[i] = 1'b1;
        d.car[i].presc_cnt = 4'h0;
        d.car[i].phase = 3'h0;
        d.car[i].in_first = 1'b1;
        d.car[i].first_cnt = {q.carrier_config[pcf_pkg::CC_WIDTH_LSB +: 4],
                              pcf_pkg::CARRIER_STEPS};
      end
      else
      begin
        if (q.car[i].presc_cnt == q.carrier_config[pcf_pkg::CC_PRESC_LSB +: 4])
        begin
          tick = 1'b1;
          d.car[i].presc_cnt = 4'h0;
        end
        else
        begin
          d.car[i].presc_cnt = q.car[i].presc_cnt + 4'h1;
        end
        if (q.car[i].in_first)
        begin
          carried[i] = 1'b1;
          if (tick)
          begin
            if (q.car[i].first_cnt == 7'h00)
            begin
              d.car[i].in_first = 1'b0;
              d.car[i].phase = 3'h0;
            end
            else
            begin
              d.car[i].first_cnt = q.car[i].first_cnt - 7'h01;
            end
          end
        end
        else
        begin
          // duty of zero gives a silent output, hence seven usable settings
          carried[i] = (q.car[i].phase < q.carrier_config[pcf_pkg::CC_DUTY_LSB +: 3]);
          if (tick)
          begin
            d.car[i].phase = q.car[i].phase + 3'h1;
          end
        end
      end
    end

    // fault events from the block-clock sampled inputs
    d.fault_smp = fault_input;
    events = q.fault_smp & {3{q.trip_config[pcf_pkg::TC_EN_BIT]}};
    ev_rise = fault_input & ~q.fault_smp & {3{q.trip_config[pcf_pkg::TC_EN_BIT]}};
    for (int k = 0; k < 3; k++)
    begin
      ev_cycle[k] = events[k] &
        (q.trip_config[pcf_pkg::TC_MODE_LSB + 2*k +: 2] == 2'(pcf_pkg::PCF_MODE_CYCLE));
      ev_latched[k] = events[k] &
        (q.trip_config[pcf_pkg::TC_MODE_LSB + 2*k +: 2] == 2'(pcf_pkg::PCF_MODE_LATCHED));
    end
    sw_cyc = reg_write & hit(pcf_pkg::OFF_TRIP_SOFTWARE) & reg_wdata[pcf_pkg::SW_CYCLE_BIT];
    sw_lat = reg_write & hit(pcf_pkg::OFF_TRIP_SOFTWARE) & reg_wdata[pcf_pkg::SW_LATCHED_BIT];
    cyc_fire = (|ev_cycle) | (sw_cyc & q.trip_config[pcf_pkg::TC_EN_BIT]);
    lat_fire = (|ev_latched) | (sw_lat & q.trip_config[pcf_pkg::TC_EN_BIT]);

    for (int k = 0; k < 3; k++)
    begin
      d.cycle_irq[k] = ev_rise[k] &
        (q.trip_config[pcf_pkg::TC_MODE_LSB + 2*k +: 2] == 2'(pcf_pkg::PCF_MODE_CYCLE));
      d.latched_irq[k] = ev_rise[k] &
        (q.trip_config[pcf_pkg::TC_MODE_LSB + 2*k +: 2] == 2'(pcf_pkg::PCF_MODE_LATCHED));
    end

    release_pt = q.trip_config[pcf_pkg::TC_RELEASE_BIT] ? timer_at_period_event
                                                        : timer_at_zero_event;
    // a new fault in the release cycle keeps the trip on
    if (cyc_fire)
      d.cycle_on = 1'b1;
    else if (release_pt)
      d.cycle_on = 1'b0;

    d.clear_prev = q.trip_config[pcf_pkg::TC_CLEAR_BIT];
    clear_now = q.trip_config[pcf_pkg::TC_CLEAR_BIT] ^ q.clear_prev;
    if (lat_fire)
      d.latched_on = 1'b1;
    else if (clear_now)
      d.latched_on = 1'b0;

    // action taken once at trip onset and held, so toggle does not oscillate
    act_a_cyc = q.trip_actions[{timer_counting_down, 1'b0} +: 2];
    act_b_cyc = q.trip_actions[4 + {timer_counting_down, 1'b0} +: 2];
    act_a_lat = q.trip_actions[8 + {timer_counting_down, 1'b0} +: 2];
    act_b_lat = q.trip_actions[12 + {timer_counting_down, 1'b0} +: 2];
    if (lat_fire && !q.latched_on)
    begin
      d.forced[0] = apply_action(act_a_lat, carried[0]);
      d.forced[1] = apply_action(act_b_lat, carried[1]);
    end
    else if (cyc_fire && !q.cycle_on && !q.latched_on)
    begin
      d.forced[0] = apply_action(act_a_cyc, carried[0]);
      d.forced[1] = apply_action(act_b_cyc, carried[1]);
    end
    if (d.latched_on || d.cycle_on)
      d.outs = d.forced;
    else
      d.outs = carried;

    // capture counter and sync
    sync_now = (q.cap_control[pcf_pkg::CAPC_TSYNC_BIT] & timer_sync_out) |
               (q.cap_control[pcf_pkg::CAPC_MSYNC_BIT] & module_sync_in) |
               (reg_write & hit(pcf_pkg::OFF_CAP_COMMAND) & reg_wdata[pcf_pkg::CMD_SYNC_BIT]);
    if (sync_now)
      d.counter = q.phase;
    else if (q.cap_control[pcf_pkg::CAPC_EN_BIT])
      d.counter = q.counter + 32'h0000_0001;

    sw_force = (reg_write & hit(pcf_pkg::OFF_CAP_COMMAND)) ?
               reg_wdata[pcf_pkg::CMD_FORCE_LSB +: 3] : 3'h0;
    for (int c = 0; c < 3; c++)
    begin
      logic x;
      logic r;
      logic f;
      logic sel;
      logic fire;
      x = capture_input[c] ^ q.chan[c].cfg[pcf_pkg::CH_INV_BIT];
      r = x & ~q.chan[c].prev_x;
      f = ~x & q.chan[c].prev_x;
      sel = (r & q.chan[c].cfg[pcf_pkg::CH_RISE_BIT]) |
            (f & q.chan[c].cfg[pcf_pkg::CH_FALL_BIT]);
      fire = 1'b0;
      d.chan[c].prev_x = x;
      if (sel)
      begin
        if (q.chan[c].presc_cnt == q.chan[c].presc)
        begin
          fire = 1'b1;
          d.chan[c].presc_cnt = 8'h00;
        end
        else
        begin
          d.chan[c].presc_cnt = q.chan[c].presc_cnt + 8'h01;
        end
      end
      if (fire)
        d.chan[c].fall_edge = f;
      if (fire || sw_force[c])
        d.chan[c].stamp = q.counter;
      d.cap_irq[c] = fire | sw_force[c];
    end

    // register writes
    if (reg_write)
    begin
      if (hit(pcf_pkg::OFF_CARRIER_CONFIG))
        d.carrier_config = {20'h0_0000, reg_wdata[11:0]};
      if (hit(pcf_pkg::OFF_TRIP_CONFIG))
        d.trip_config = {23'h00_0000, reg_wdata[8:0]};
      if (hit(pcf_pkg::OFF_TRIP_ACTIONS))
        d.trip_actions = {16'h0000, reg_wdata[15:0]};
      if (hit(pcf_pkg::OFF_CAP_CONTROL))
        d.cap_control = reg_wdata[2:0];
      if (hit(pcf_pkg::OFF_CAP_PHASE))
        d.phase = reg_wdata;
      for (int c = 0; c < 3; c++)
      begin
        if (reg_addr == pcf_pkg::OFF_CHAN_CFG0 + 8'(4*c))
        begin
          d.chan[c].cfg = {1'b0, reg_wdata[2:0]};
          d.chan[c].presc = reg_wdata[pcf_pkg::CH_PRESC_LSB +: 8];
          d.chan[c].presc_cnt = 8'h00;
        end
      end
    end

    // register reads, data valid in the next cycle only
    d.rd_data = 32'h0000_0000;
    if (reg_read)
    begin
      if (hit(pcf_pkg::OFF_CARRIER_CONFIG))
        d.rd_data = q.carrier_config;
      if (hit(pcf_pkg::OFF_TRIP_CONFIG))
        d.rd_data = q.trip_config;
      if (hit(pcf_pkg::OFF_TRIP_ACTIONS))
        d.rd_data = q.trip_actions;
      if (hit(pcf_pkg::OFF_TRIP_STATUS))
        d.rd_data = {27'h000_0000, q.fault_smp, q.latched_on, q.cycle_on};
      if (hit(pcf_pkg::OFF_CAP_CONTROL))
        d.rd_data = {29'h0000_0000, q.cap_control};
      if (hit(pcf_pkg::OFF_CAP_PHASE))
        d.rd_data = q.phase;
      if (hit(pcf_pkg::OFF_EDGE_KIND))
        d.rd_data = {29'h0000_0000, q.chan[2].fall_edge, q.chan[1].fall_edge,
                     q.chan[0].fall_edge};
      if (hit(pcf_pkg::OFF_CAP_COUNTER))
        d.rd_data = q.counter;
      for (int c = 0; c < 3; c++)
      begin
        if (reg_addr == pcf_pkg::OFF_CHAN_CFG0 + 8'(4*c))
          d.rd_data = {21'h00_0000, q.chan[c].presc, q.chan[c].cfg[2:0]};
        if (reg_addr == pcf_pkg::OFF_TIMESTAMP0 + 8'(4*c))
          d.rd_data = q.chan[c].stamp;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.carrier_config <= pcf_pkg::CC_RESET;
      q.trip_config <= pcf_pkg::TC_RESET;
      q.trip_actions <= pcf_pkg::TA_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata           = q.rd_data;
  assign output_a            = q.outs[0];
  assign output_b            = q.outs[1];
  assign cycle_trip_active   = q.cycle_on;
  assign latched_trip_active = q.latched_on;
  assign cycle_trip_irq      = q.cycle_irq;
  assign latched_trip_irq    = q.latched_irq;
  assign capture_irq         = q.cap_irq;

endmodule // pcf_top

`default_nettype wire

// ==== design/pcf_pkg.sv ====
// constants, register map and state carriers for the pwm carrier, trip and capture block
// assumes one 40 MHz clock, inputs already synchronous to it, a plain strobe register port
package pcf_pkg;

  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] OFF_CARRIER_CONFIG = 8'h00;
  localparam logic [7:0] OFF_TRIP_CONFIG    = 8'h04;
  localparam logic [7:0] OFF_TRIP_ACTIONS   = 8'h08;
  localparam logic [7:0] OFF_TRIP_SOFTWARE  = 8'h0C;
  localparam logic [7:0] OFF_TRIP_STATUS    = 8'h10;
  localparam logic [7:0] OFF_CAP_CONTROL    = 8'h14;
  localparam logic [7:0] OFF_CAP_COMMAND    = 8'h18;
  localparam logic [7:0] OFF_CAP_PHASE      = 8'h1C;
  localparam logic [7:0] OFF_CHAN_CFG0      = 8'h20;
  localparam logic [7:0] OFF_TIMESTAMP0     = 8'h2C;
  localparam logic [7:0] OFF_EDGE_KIND      = 8'h38;
  localparam logic [7:0] OFF_CAP_COUNTER    = 8'h3C;

  // carrier_config fields
  localparam int unsigned CC_EN_BIT     = 0;
  localparam int unsigned CC_PRESC_LSB  = 1;
  localparam int unsigned CC_DUTY_LSB   = 5;
  localparam int unsigned CC_WIDTH_LSB  = 8;
  localparam logic [31:0] CC_RESET      = 32'h0000_0000;
  // last carrier_clock tick index per sustaining period and per first-pulse width step (eight ticks each)
  localparam logic [2:0]  CARRIER_STEPS = 3'h7;

  // trip_config fields
  localparam int unsigned TC_EN_BIT      = 0;
  localparam int unsigned TC_MODE_LSB    = 1;
  localparam int unsigned TC_RELEASE_BIT = 7;
  localparam int unsigned TC_CLEAR_BIT   = 8;
  localparam logic [31:0] TC_RESET       = 32'h0000_0000;
  localparam logic [31:0] TA_RESET       = 32'h0000_0000;

  // trip_software and cap_command pulse bits
  localparam int unsigned SW_CYCLE_BIT   = 0;
  localparam int unsigned SW_LATCHED_BIT = 1;
  localparam int unsigned CMD_SYNC_BIT   = 0;
  localparam int unsigned CMD_FORCE_LSB  = 1;

  // cap_control fields
  localparam int unsigned CAPC_EN_BIT    = 0;
  localparam int unsigned CAPC_TSYNC_BIT = 1;
  localparam int unsigned CAPC_MSYNC_BIT = 2;

  // channel config fields
  localparam int unsigned CH_INV_BIT    = 0;
  localparam int unsigned CH_RISE_BIT   = 1;
  localparam int unsigned CH_FALL_BIT   = 2;
  localparam int unsigned CH_PRESC_LSB  = 3;

  typedef enum logic [1:0] {PCF_MODE_NONE, PCF_MODE_CYCLE, PCF_MODE_LATCHED, PCF_MODE_SPARE}
    pcf_mode_e;
  typedef enum logic [1:0] {PCF_ACT_NONE, PCF_ACT_LOW, PCF_ACT_HIGH, PCF_ACT_TOGGLE} pcf_act_e;

  typedef struct packed {
    logic       prev_in;
    logic [3:0] presc_cnt;
    logic [2:0] phase;
    logic [6:0] first_cnt;
    logic       in_first;
  } pcf_carrier_s;

  typedef struct packed {
    logic       prev_x;
    logic [7:0] presc_cnt;
    logic [7:0] presc;
    logic       fall_edge;
    logic [31:0] stamp;
    logic [3:0] cfg;
  } pcf_chan_s;

  typedef struct packed {
    logic [31:0]       carrier_config;
    logic [31:0]       trip_config;
    logic [31:0]       trip_actions;
    logic [2:0]        cap_control;
    logic [31:0]       phase;
    logic [31:0]       counter;
    pcf_chan_s [2:0]   chan;
    pcf_carrier_s [1:0] car;
    logic [2:0]        fault_smp;
    logic              clear_prev;
    logic              cycle_on;
    logic              latched_on;
    logic [1:0]        forced;
    logic [1:0]        outs;
    logic [2:0]        cycle_irq;
    logic [2:0]        latched_irq;
    logic [2:0]        cap_irq;
    logic [31:0]       rd_data;
  } pcf_state_s;

endpackage

// ==== dv/pcf_asserts.sv ====
// port-level checker for pcf_top
// assumes the single clk domain with rst_n as its asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module pcf_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        pwm_a_in,
  input wire logic        pwm_b_in,
  input wire logic        timer_at_period_event,
  input wire logic        timer_at_zero_event,
  input wire logic [2:0]  fault_input,
  input wire logic        output_a,
  input wire logic        output_b,
  input wire logic        cycle_trip_active,
  input wire logic        latched_trip_active,
  input wire logic [2:0]  cycle_trip_irq,
  input wire logic [2:0]  latched_trip_irq,
  input wire logic [2:0]  capture_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its answer cycle");
  a_cycle_hold: assert property (cycle_trip_active && !timer_at_period_event &&
    !timer_at_zero_event && !reg_write |=> cycle_trip_active)
    else $error("cycle trip dropped away from a release point");
  // the clear toggle is seen one cycle after its write, so two write cycles are excused
  a_latched_hold: assert property (latched_trip_active && !reg_write
    && !$past(reg_write) |=> latched_trip_active)
    else $error("latched trip dropped without software");
  a_cycle_set: assert property (|cycle_trip_irq |-> ##[0:2] cycle_trip_active)
    else $error("cycle trip flag missing after its interrupt");
  a_latched_set: assert property (|latched_trip_irq |-> ##[0:2] latched_trip_active)
    else $error("latched trip flag missing after its interrupt");
  a_irq_cause: assert property (((cycle_trip_irq | latched_trip_irq)
    & ~$past(fault_input)) == 3'h0) else $error("trip interrupt without its fault");
  a_irq_pulse: assert property ((cycle_trip_irq & $past(cycle_trip_irq)) == 3'h0)
    else $error("trip interrupt longer than one cycle");
  a_cap_pulse: assert property ((capture_irq & $past(capture_irq)) == 3'h0)
    else $error("capture interrupt longer than one cycle");
  a_out_low: assert property (!$past(pwm_a_in | pwm_b_in) && !cycle_trip_active
    && !latched_trip_active && !$past(cycle_trip_active | latched_trip_active)
    |-> !output_a && !output_b) else $error("output high while its input is low");
endmodule // pcf_asserts

bind pcf_top pcf_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pwm_a_in(pwm_a_in), .pwm_b_in(pwm_b_in),
  .timer_at_period_event(timer_at_period_event), .timer_at_zero_event(timer_at_zero_event),
  .fault_input(fault_input), .output_a(output_a), .output_b(output_b),
  .cycle_trip_active(cycle_trip_active), .latched_trip_active(latched_trip_active),
  .cycle_trip_irq(cycle_trip_irq), .latched_trip_irq(latched_trip_irq),
  .capture_irq(capture_irq)
);

`default_nettype wire

// ==== dv/pcf_fault_src.sv ====
// external fault source: stretches each request into a held fault level
// assumes requests are one-cycle pulses on the block clock
`timescale 1ns/1ps
`default_nettype none

module pcf_fault_src #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] req,
  output logic      [2:0] fault
);
  logic [2:0][3:0] cnt_q;

  // one clock domain here, so two bus cycles plus one block cycle is three at least
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      for (int i = 0; i < 3; i++)
        cnt_q[i] <= req[i] ? 4'(HOLD) : (cnt_q[i] != 4'h0 ? cnt_q[i] - 4'h1 : 4'h0);
  end

  always_comb
    for (int i = 0; i < 3; i++)
      fault[i] = cnt_q[i] != 4'h0;
endmodule // pcf_fault_src

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for pcf_top with a fault source model
// assumes 40 MHz clk; reads are checked from a queue by a monitor process
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, pwm = 0, tdown = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, r, r2;
  logic [3:0]  evs = 4'h0, p, w;
  logic [2:0]  req = 3'h0, capi = 3'h0, fault, cirq, lirq, kirq, d;
  logic        out_a, out_b, cta, lta, rd_pend = 0;
  logic [8:0]  irq_seen = 9'h000;
  logic [31:0] rd_q[$], run_q[$];
  int          errors = 0, n_tests = 0, run = 0;

  pcf_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pwm_a_in(pwm),
    .pwm_b_in(pwm), .timer_counting_down(tdown), .timer_at_period_event(evs[0]),
    .timer_at_zero_event(evs[1]), .fault_input(fault), .capture_input(capi),
    .timer_sync_out(evs[2]), .module_sync_in(evs[3]), .output_a(out_a), .output_b(out_b),
    .cycle_trip_active(cta), .latched_trip_active(lta), .cycle_trip_irq(cirq),
    .latched_trip_irq(lirq), .capture_irq(kirq));
  pcf_fault_src i_src (.clk(clk), .rst_n(rst_n), .req(req), .fault(fault));

  initial forever #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // monitor: read answers and high-run lengths of output_a against notes
  always @(posedge clk)
  begin
    if (rd_pend) check(reg_rdata, rd_q.pop_front());
    rd_pend = reg_read;
    if (out_a) run++;
    else if (run != 0)
    begin
      if (run_q.size() > 0) check(run, run_q.pop_front());
      run = 0;
    end
    irq_seen |= {kirq, lirq, cirq};
  end

  // strobes are lowered here, and wr and rd each lower the other strobe, so back-to-back accesses never assign twice per step
  task automatic bus_idle();
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
  endtask
  task automatic cyc(input int n);
    bus_idle();
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_read  <= 1'b0;
    reg_write <= 1'b1;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    reg_addr  <= a;
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clk);
  endtask
  task automatic ev(input int k);
    bus_idle();
    evs <= 4'h1 << k;
    @(posedge clk);
    evs <= 4'h0;
    cyc(2);
  endtask
  task automatic flt(input int k);
    bus_idle();
    req <= 3'h1 << k;
    @(posedge clk);
    req <= 3'h0;
    cyc(8);
  endtask
  task automatic look(input logic oe, input logic [8:0] ie);
    bus_idle();
    @(negedge clk);
    check({31'h0, out_a}, {31'h0, oe});
    check({23'h0, irq_seen}, {23'h0, ie});
    irq_seen = 9'h000;
    @(posedge clk);
  endtask

  initial
  begin
    #(25ns * 10000);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    r = $urandom(32'hb742);
    rd(pcf_pkg::OFF_CARRIER_CONFIG, pcf_pkg::CC_RESET);
    rd(pcf_pkg::OFF_TRIP_CONFIG, pcf_pkg::TC_RESET);
    rd(pcf_pkg::OFF_TRIP_ACTIONS, pcf_pkg::TA_RESET);
    rd(8'hFC, 32'h0000_0000);
    rd(pcf_pkg::OFF_TRIP_SOFTWARE, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      p = 4'($urandom_range(0, 3)); w = 4'($urandom_range(0, 3));
      d = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom_range(1, 7));
      wr(pcf_pkg::OFF_CARRIER_CONFIG, {20'h0, w, d, p, 1'b1});
      run_q.push_back(1 + 8 * (p + 1) * (w + 1) + d * (p + 1));
      if (d != 3'h0) repeat (2) run_q.push_back(d * (p + 1));
      pwm <= 1'b1; cyc(1 + 8 * (p + 1) * (w + 1) + 40 * (p + 1)); pwm <= 1'b0; cyc(12);
    end
    wr(pcf_pkg::OFF_CARRIER_CONFIG, 32'h0000_0F6E);
    run_q.push_back(20);
    pwm <= 1'b1; cyc(20); pwm <= 1'b0; cyc(4);
    wr(pcf_pkg::OFF_TRIP_ACTIONS, 32'h0000_2206);
    wr(pcf_pkg::OFF_TRIP_CONFIG, 32'h0000_0093);
    rd(pcf_pkg::OFF_TRIP_CONFIG, 32'h0000_0093);
    flt(0); look(1'b1, 9'h001);
    rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0001);
    ev(1); rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0001);
    ev(0); rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0000);
    flt(1); look(1'b1, 9'h010);
    ev(0); rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0002);
    wr(pcf_pkg::OFF_TRIP_CONFIG, 32'h0000_0193); cyc(2);
    rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0000);
    wr(pcf_pkg::OFF_TRIP_SOFTWARE, 32'h0000_0001); cyc(2);
    rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0001); look(1'b1, 9'h000);
    ev(0);
    pwm <= 1'b1; tdown <= 1'b1;
    flt(0); look(1'b0, 9'h001);
    ev(0); look(1'b1, 9'h000);
    pwm <= 1'b0; tdown <= 1'b0;
    wr(pcf_pkg::OFF_TRIP_CONFIG, 32'h0000_0192);
    wr(pcf_pkg::OFF_TRIP_SOFTWARE, 32'h0000_0002);
    flt(1); rd(pcf_pkg::OFF_TRIP_STATUS, 32'h0000_0000); look(1'b0, 9'h000);
    r = $urandom(); r2 = $urandom();
    wr(pcf_pkg::OFF_CAP_PHASE, r); wr(pcf_pkg::OFF_CAP_CONTROL, 32'h0000_0000);
    wr(pcf_pkg::OFF_CAP_COMMAND, 32'h0000_0001); cyc(2);
    rd(pcf_pkg::OFF_CAP_COUNTER, r);
    wr(pcf_pkg::OFF_CHAN_CFG0, 32'h0000_0002); wr(pcf_pkg::OFF_CHAN_CFG0 + 8'h04, 32'h0000_0005);
    // let the new inversion reach the edge detector before the input moves
    cyc(1);
    capi <= 3'h3; cyc(3); look(1'b0, 9'h0C0);
    capi <= 3'h0; cyc(3); look(1'b0, 9'h000);
    rd(pcf_pkg::OFF_TIMESTAMP0, r); rd(pcf_pkg::OFF_TIMESTAMP0 + 8'h04, r);
    rd(pcf_pkg::OFF_EDGE_KIND, 32'h0000_0002);
    wr(pcf_pkg::OFF_CAP_COMMAND, 32'h0000_0008); cyc(2); look(1'b0, 9'h100);
    rd(pcf_pkg::OFF_TIMESTAMP0 + 8'h08, r); rd(pcf_pkg::OFF_EDGE_KIND, 32'h0000_0002);
    wr(pcf_pkg::OFF_CAP_PHASE, r2); wr(pcf_pkg::OFF_CAP_COMMAND, 32'h0000_0001);
    wr(pcf_pkg::OFF_CHAN_CFG0, 32'h0000_000A);
    capi <= 3'h1; cyc(3); capi <= 3'h0; cyc(3); look(1'b0, 9'h000);
    capi <= 3'h1; cyc(3); capi <= 3'h0; cyc(3); look(1'b0, 9'h040);
    rd(pcf_pkg::OFF_TIMESTAMP0, r2);
    wr(pcf_pkg::OFF_CAP_CONTROL, 32'h0000_0001); cyc(29);
    wr(pcf_pkg::OFF_CAP_CONTROL, 32'h0000_0000); cyc(2);
    rd(pcf_pkg::OFF_CAP_COUNTER, r2 + 32'h0000_001E);
    for (int k = 0; k < 2; k++)
    begin
      wr(pcf_pkg::OFF_CAP_PHASE, r + k); wr(pcf_pkg::OFF_CAP_CONTROL, 32'h0000_0002 << k);
      ev(2 + k); rd(pcf_pkg::OFF_CAP_COUNTER, r + k);
    end
    cyc(4);
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
